// file: include/bgc_pkg.sv
package bgc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_MODE     = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h01;
  localparam logic [7:0] ADDR_CHG_LO   = 8'h02;
  localparam logic [7:0] ADDR_CHG_HI   = 8'h03;
  localparam logic [7:0] ADDR_CNT_LO   = 8'h04;
  localparam logic [7:0] ADDR_CNT_HI   = 8'h05;
  localparam logic [7:0] ADDR_CUR_LO   = 8'h06;
  localparam logic [7:0] ADDR_CUR_HI   = 8'h07;
  localparam logic [7:0] ADDR_VOLT_LO  = 8'h08;
  localparam logic [7:0] ADDR_VOLT_HI  = 8'h09;
  localparam logic [7:0] ADDR_TEMP_LO  = 8'h0A;
  localparam logic [7:0] ADDR_TEMP_HI  = 8'h0B;
  localparam logic [7:0] ADDR_ID_BASE  = 8'h18;
  localparam logic [7:0] ADDR_RAM_BASE = 8'h20;
  localparam logic [7:0] ADDR_RAM_LAST = 8'h3F;
  localparam int         RAM_BYTES     = 32;
  localparam int         ID_BYTES      = 8;
  // Mode register fields
  localparam int MODE_EXTCLK = 0;
  localparam int MODE_RES_LO = 1;
  localparam int MODE_CAL    = 3;
  localparam int MODE_RUN    = 4;
  // Control register fields
  localparam int CTRL_GPIO   = 0;
  localparam int CTRL_POR    = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Resolution codes
  localparam logic [1:0] RES_14 = 2'b00;
  localparam logic [1:0] RES_13 = 2'b01;
  localparam logic [1:0] RES_12 = 2'b10;
  // Time base figures
  localparam int TB_HZ        = 32768;
  localparam int VT_PERIOD_S  = 2;
  localparam int VT_CONV_TB   = 8192;
  localparam int VT_PERIOD_TB = TB_HZ * VT_PERIOD_S;
  localparam int ACC_W        = 28;
  localparam int CRC_POLY     = 8'h07;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bgc_bus_t;

  typedef struct packed {
    logic        done;
    logic [15:0] value;
  } bgc_conv_t;
endpackage

// file: hdl/bgc_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; change accepted when stages 2 and 3 agree
module bgc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Async in, clean out
  input  wire logic asyncIn,
  output logic      syncOut
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } bgc_sync_st_t;

  bgc_sync_st_t st_q;
  bgc_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = asyncIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.out = st_q.s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign syncOut = st_q.out;
endmodule

// file: hdl/bgc_crc8.sv
`timescale 1ns/1ps
// Combinational CRC-8 over the first seven id bytes, init zero
module bgc_crc8 (
  // Id bytes 0..6, byte 0 in low bits
  input  wire logic [55:0] idBytes,
  // Check byte
  output logic [7:0]       crc
);
  logic [7:0] acc;
  always_comb begin
    acc = 8'h00;
    for (int b = 0; b < 7; b++) begin
      acc = acc ^ idBytes[b*8 +: 8];
      for (int i = 0; i < 8; i++) begin
        if (acc[7]) begin
          acc = {acc[6:0], 1'b0} ^ 8'(bgc_pkg::CRC_POLY);
        end else begin
          acc = {acc[6:0], 1'b0};
        end
      end
    end
    crc = acc;
  end
endmodule

// file: hdl/battery_gauge_core.sv
`timescale 1ns/1ps
// Function
// - Each current conversion end adds signed result to 28-bit accumulator.
// - Host reads only the upper 16 accumulator bits.
// - Each finished current conversion bumps a 16-bit counter.
// - Latest current result lands in current registers at conversion end.
// - Calibration bit high shorts current converter inputs together.
// - Current conversion lasts 2^n time-base cycles at n-bit resolution.
// - Undervoltage stops the gauge and holds standby.
// - Registers kept above reset level; power-on reset restores defaults.
// - Timing from a 32768 Hz base, internal or external.
// - Voltage or temperature conversion every two seconds, alternating.
// - Voltage/temperature conversion lasts 8192 time-base cycles.
// - Voltage/temperature sequencing runs beside current conversions.
// - Pin bit 0 drives pin low, 1 releases it.
// - Reading the pin bit returns the sampled pin level.
// - Standby, power-on flag or undervoltage release pin, read zero.
// - 32 RAM bytes persist until power-on reset.
// - Identifier is type byte, 48-bit unique value, check byte.
// - Check byte is CRC-8 poly 0x07, init zero, over bytes 0..6.
// - Identifier copied at power-up into read-only slots beside RAM.
// - Run bit clear: standby, accumulator and counter frozen.
// - Resolution code 00 is 14-bit, 01 13-bit, 10 12-bit.
// - Unused low current bits read zero at reduced resolution.
module battery_gauge_core #(
  parameter logic [7:0]  PART_TYPE = 8'h5A, // Arbitrary value
  parameter logic [47:0] UNIQUE_ID = 48'h0123456789AB // Arbitrary value
) (
  // Clock and reset (reset is the power-on reset)
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  // Time base ticks (async pins)
  input  wire logic        intTbClk,
  input  wire logic        extTbClk,
  // Supply monitor
  input  wire logic        undervoltage,
  // Current converter
  input  wire logic [13:0] curAdcData,
  output logic             curAdcShort,
  output logic             curAdcSample,
  // Voltage/temperature converter
  input  wire logic [15:0] vtAdcData,
  output logic             vtAdcSelTemp,
  output logic             vtAdcStart,
  // General-purpose pin, open drain
  input  wire logic        gpioPinIn,
  output logic             gpioPinOut,
  output logic             gpioPinOe,
  // Status
  output logic             gaugeActive
);
  typedef enum logic [1:0] {VtIdle, VtConv} bgc_vt_st_t;

  typedef struct packed {
    logic [7:0]       mode;
    logic             gpioPinBit;
    logic             powerOnFlag;
    logic             tbPrev;
    logic [13:0]      curCnt;
    logic [16:0]      vtCnt;
    bgc_vt_st_t       vtState;
    logic             vtSelTemp;
    logic [27:0]      acc;
    logic [15:0]      convCnt;
    logic [15:0]      current;
    logic [15:0]      voltage;
    logic [15:0]      temperature;
    logic [7:0]       snapHi;
    logic [7:0]       rdata;
    logic             curSample;
    logic             vtStart;
  } bgc_state_t;

  bgc_state_t st_q;
  bgc_state_t st_d;
  logic [7:0] ram_q [bgc_pkg::RAM_BYTES];
  logic [7:0] idBytes [bgc_pkg::ID_BYTES];
  logic [7:0] idCrc;
  logic       intTbSync;
  logic       extTbSync;
  logic       gpioSync;
  logic       tbNow;
  logic       tbTick;
  logic       running;
  logic [1:0] res;
  logic [4:0] resBits;
  logic [13:0] curLen;
  logic [15:0] curAligned;
  logic [15:0] curMasked;
  logic [7:0] readByte;
  logic [5:0] ramIdx;
  logic [2:0] idIdx;
  bgc_pkg::bgc_bus_t bus;

  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Pin synchronisers
  bgc_sync uIntTb (.clk(clk), .rst(rst), .asyncIn(intTbClk),
                   .syncOut(intTbSync));
  bgc_sync uExtTb (.clk(clk), .rst(rst), .asyncIn(extTbClk),
                   .syncOut(extTbSync));
  bgc_sync uGpio (.clk(clk), .rst(rst), .asyncIn(gpioPinIn),
                  .syncOut(gpioSync));

  // Identifier image, check byte computed from the first seven
  bgc_crc8 uCrc (
    .idBytes({UNIQUE_ID, PART_TYPE}),
    .crc    (idCrc)
  );

  // Read-only id slots, fixed from power-up on
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gId
      assign idBytes[g+1] = UNIQUE_ID[g*8 +: 8];
    end
  endgenerate
  assign idBytes[0] = PART_TYPE;
  assign idBytes[7] = idCrc;

  // Time base select and edge detect
  assign tbNow = st_q.mode[bgc_pkg::MODE_EXTCLK] ? extTbSync
                                                 : intTbSync;
  assign tbTick = tbNow & ~st_q.tbPrev;
  assign running = st_q.mode[bgc_pkg::MODE_RUN]
                   & ~undervoltage;
  assign res = st_q.mode[bgc_pkg::MODE_RES_LO +: 2];

  // Resolution decode
  always_comb begin
    unique case (res)
      bgc_pkg::RES_13: resBits = 5'd13;
      bgc_pkg::RES_12: resBits = 5'd12;
      default:         resBits = 5'd14;
    endcase
  end
  assign curLen = 14'((15'd1 << resBits) - 15'd1);

  // Sign-extend raw result, clear low bits below resolution
  assign curAligned = {{2{curAdcData[13]}}, curAdcData};
  always_comb begin
    curMasked = curAligned;
    if (resBits == 5'd13) begin
      curMasked[0] = 1'b0;
    end else if (resBits == 5'd12) begin
      curMasked[1:0] = 2'b00;
    end
  end

  // Read mux
  assign ramIdx = 6'(bus.addr - bgc_pkg::ADDR_RAM_BASE);
  assign idIdx  = 3'(bus.addr - bgc_pkg::ADDR_ID_BASE);
  always_comb begin
    readByte = 8'h00;
    if (bus.addr >= bgc_pkg::ADDR_RAM_BASE &&
        bus.addr <= bgc_pkg::ADDR_RAM_LAST) begin
      readByte = ram_q[ramIdx[4:0]];
    end else if (bus.addr >= bgc_pkg::ADDR_ID_BASE &&
                 bus.addr < bgc_pkg::ADDR_RAM_BASE) begin
      readByte = idBytes[idIdx];
    end else begin
      unique case (bus.addr)
        bgc_pkg::ADDR_MODE:    readByte = st_q.mode;
        bgc_pkg::ADDR_CTRL: begin
          readByte[bgc_pkg::CTRL_GPIO] = running & ~st_q.powerOnFlag
                                       & gpioSync;
          readByte[bgc_pkg::CTRL_POR] = st_q.powerOnFlag;
        end
        bgc_pkg::ADDR_CHG_LO:  readByte = st_q.acc[19:12];
        bgc_pkg::ADDR_CHG_HI:  readByte = st_q.snapHi;
        bgc_pkg::ADDR_CNT_LO:  readByte = st_q.convCnt[7:0];
        bgc_pkg::ADDR_CNT_HI:  readByte = st_q.snapHi;
        bgc_pkg::ADDR_CUR_LO:  readByte = st_q.current[7:0];
        bgc_pkg::ADDR_CUR_HI:  readByte = st_q.snapHi;
        bgc_pkg::ADDR_VOLT_LO: readByte = st_q.voltage[7:0];
        bgc_pkg::ADDR_VOLT_HI: readByte = st_q.snapHi;
        bgc_pkg::ADDR_TEMP_LO: readByte = st_q.temperature[7:0];
        bgc_pkg::ADDR_TEMP_HI: readByte = st_q.snapHi;
        default:               readByte = 8'h00;
      endcase
    end
  end

  // Next state
  always_comb begin
    st_d           = st_q;
    st_d.tbPrev    = tbNow;
    st_d.curSample = 1'b0;
    st_d.vtStart   = 1'b0;
    // Register writes
    if (bus.wr) begin
      if (bus.addr == bgc_pkg::ADDR_MODE) begin
        st_d.mode = bus.wdata;
      end
      if (bus.addr == bgc_pkg::ADDR_CTRL) begin
        st_d.gpioPinBit  = bus.wdata[bgc_pkg::CTRL_GPIO];
        if (!bus.wdata[bgc_pkg::CTRL_POR]) begin
          st_d.powerOnFlag = 1'b0;
        end
      end
    end
    // Read data and high-byte snapshot taken with the low byte
    if (bus.rd) begin
      st_d.rdata = readByte;
      unique case (bus.addr)
        bgc_pkg::ADDR_CHG_LO:  st_d.snapHi = st_q.acc[27:20];
        bgc_pkg::ADDR_CNT_LO:  st_d.snapHi = st_q.convCnt[15:8];
        bgc_pkg::ADDR_CUR_LO:  st_d.snapHi = st_q.current[15:8];
        bgc_pkg::ADDR_VOLT_LO: st_d.snapHi = st_q.voltage[15:8];
        bgc_pkg::ADDR_TEMP_LO: st_d.snapHi = st_q.temperature[15:8];
        default:               st_d.snapHi = st_q.snapHi;
      endcase
    end else begin
      st_d.rdata = 8'h00;
    end
    // Current conversion timing
    if (running && tbTick) begin
      if (st_q.curCnt >= curLen) begin
        st_d.curCnt    = '0;
        st_d.curSample = 1'b1;
        st_d.acc       = st_q.acc
                         + {{12{curMasked[15]}}, curMasked};
        st_d.convCnt   = st_q.convCnt + 16'd1;
        st_d.current   = curMasked;
      end else begin
        st_d.curCnt = st_q.curCnt + 14'd1;
      end
    end
    // Voltage/temperature sequencer, independent of current path
    if (running && tbTick) begin
      if (st_q.vtCnt >= 17'(bgc_pkg::VT_PERIOD_TB - 1)) begin
        st_d.vtCnt = '0;
      end else begin
        st_d.vtCnt = st_q.vtCnt + 17'd1;
      end
      unique case (st_q.vtState)
        VtIdle: begin
          if (st_q.vtCnt == '0) begin
            st_d.vtState = VtConv;
            st_d.vtStart = 1'b1;
          end
        end
        VtConv: begin
          if (st_q.vtCnt == 17'(bgc_pkg::VT_CONV_TB - 1)) begin
            st_d.vtState = VtIdle;
            if (st_q.vtSelTemp) begin
              st_d.temperature = vtAdcData;
            end else begin
              st_d.voltage = vtAdcData;
            end
            st_d.vtSelTemp = ~st_q.vtSelTemp;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q             <= '0;
      st_q.mode        <= bgc_pkg::MODE_RESET;
      st_q.gpioPinBit  <= 1'b1;
      st_q.powerOnFlag <= 1'b1;
      st_q.vtState     <= VtIdle;
    end else begin
      st_q <= st_d;
    end
  end

  // RAM bytes, cleared only by power-on reset
  generate
    for (g = 0; g < bgc_pkg::RAM_BYTES; g++) begin : gRam
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ram_q[g] <= 8'h00;
        end else if (bus.wr && bus.addr == 8'(bgc_pkg::ADDR_RAM_BASE + g)) begin
          ram_q[g] <= bus.wdata;
        end
      end
    end
  endgenerate

  // Outputs
  assign regRdata     = st_q.rdata;
  assign curAdcShort  = st_q.mode[bgc_pkg::MODE_CAL];
  assign curAdcSample = st_q.curSample;
  assign vtAdcSelTemp = st_q.vtSelTemp;
  assign vtAdcStart   = st_q.vtStart;
  assign gaugeActive  = running;
  assign gpioPinOut   = 1'b0;
  assign gpioPinOe    = running & ~st_q.powerOnFlag
                        & ~st_q.gpioPinBit;
endmodule

// file: verif/bgc_checker.sv
`timescale 1ns/1ps
// Port-level checks of the gauge core
module bgc_checker #(
  parameter logic [7:0] PART_TYPE = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [7:0]  regRdata,
  // Supply and converters
  input  wire logic        undervoltage,
  input  wire logic        curAdcShort,
  input  wire logic        curAdcSample,
  input  wire logic        vtAdcStart,
  // Pin and status
  input  wire logic        gpioPinOut,
  input  wire logic        gpioPinOe,
  input  wire logic        gaugeActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cal_short: assert property (
    regWr && regAddr == bgc_pkg::ADDR_MODE
    |=> curAdcShort == $past(regWdata[3]))
    else $error("Calibration short does not follow mode bit");
  a_run_follows: assert property (
    regWr && regAddr == bgc_pkg::ADDR_MODE && !undervoltage
    ##1 !undervoltage |-> gaugeActive == $past(regWdata[4]))
    else $error("Gauge activity does not follow run bit");
  a_uv_stops: assert property (
    undervoltage |-> !gaugeActive)
    else $error("Gauge active during undervoltage");
  a_sample_gap: assert property (
    curAdcSample |=> !curAdcSample [*8])
    else $error("Current conversions too close");
  a_vt_gap: assert property (
    vtAdcStart |=> !vtAdcStart [*8])
    else $error("Voltage or temperature starts too close");
  a_standby_idle: assert property (
    !gaugeActive [*2] |-> !curAdcSample)
    else $error("Current conversion ended in standby");
  a_vt_idle: assert property (
    !gaugeActive [*2] |-> !vtAdcStart)
    else $error("Monitor conversion started in standby");
  a_pin_open: assert property (
    !gaugeActive |-> !gpioPinOe)
    else $error("Pin driven while gauge inactive");
  a_pin_low: assert property (
    gpioPinOe |-> gpioPinOut == 1'b0)
    else $error("Pin driven to a high level");
  a_id_type: assert property (
    regRd && regAddr == bgc_pkg::ADDR_ID_BASE |=> regRdata == PART_TYPE)
    else $error("Part type byte wrong");
endmodule

bind battery_gauge_core bgc_checker #(.PART_TYPE(PART_TYPE)) u_chk (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .undervoltage(undervoltage), .curAdcShort(curAdcShort),
  .curAdcSample(curAdcSample), .vtAdcStart(vtAdcStart),
  .gpioPinOut(gpioPinOut), .gpioPinOe(gpioPinOe),
  .gaugeActive(gaugeActive));

// file: verif/bgc_front_model.sv
`timescale 1ns/1ps
// Converters, time bases and pulled-up pin
module bgc_front_model (
  // Clock
  input  wire logic        clk,
  // Bench controls
  input  wire logic [13:0] curVal,
  input  wire logic        extLow,
  // From core
  input  wire logic        curAdcShort,
  input  wire logic        vtAdcSelTemp,
  input  wire logic        gpioPinOut,
  input  wire logic        gpioPinOe,
  // To core
  output logic             intTbClk,
  output logic             extTbClk,
  output logic      [13:0] curAdcData,
  output logic      [15:0] vtAdcData,
  output logic             gpioPinIn
);
  int tbCnt = 0;
  initial begin
    intTbClk = 1'b0;
    extTbClk = 1'b0;
  end
  // Time bases sped up: 8 and 10 clocks a tick
  always @(posedge clk) begin
    tbCnt <= (tbCnt + 1) % 40;
    intTbClk <= (tbCnt % 8) < 4;
    extTbClk <= (tbCnt % 10) < 5;
  end
  // Shorted inputs give only the offset
  assign curAdcData = curAdcShort ? 14'h0002 : curVal;
  assign vtAdcData = vtAdcSelTemp ? 16'h00C8 : 16'h0600;
  // Pull-up when released
  assign gpioPinIn = ~(gpioPinOe & ~gpioPinOut) & ~extLow;
endmodule

// file: verif/battery_gauge_core_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module battery_gauge_core_tb;
  localparam logic [7:0]  PT  = 8'h3C; // Arbitrary value
  localparam logic [47:0] UID = 48'hA1B2C3D4E5F6; // Arbitrary value
  logic        clk = 0, rst = 1, regWr = 0, regRd = 0;
  logic        undervoltage = 0, extLow = 0;
  logic [7:0]  regAddr = 0, regWdata = 0, regRdata, d;
  logic [13:0] curVal = 0, curAdcData;
  logic [15:0] vtAdcData, v;
  logic        intTbClk, extTbClk, curAdcShort, curAdcSample, vtAdcSelTemp;
  logic        vtAdcStart, gpioPinIn, gpioPinOut, gpioPinOe, gaugeActive;
  int          miscompares = 0, total_checks = 0, n;
  always #12.5 clk = ~clk;

  battery_gauge_core #(.PART_TYPE(PT), .UNIQUE_ID(UID)) dut (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .intTbClk(intTbClk), .extTbClk(extTbClk), .undervoltage(undervoltage),
    .curAdcData(curAdcData), .curAdcShort(curAdcShort),
    .curAdcSample(curAdcSample), .vtAdcData(vtAdcData),
    .vtAdcSelTemp(vtAdcSelTemp), .vtAdcStart(vtAdcStart),
    .gpioPinIn(gpioPinIn), .gpioPinOut(gpioPinOut), .gpioPinOe(gpioPinOe),
    .gaugeActive(gaugeActive));
  bgc_front_model u_front (
    .clk(clk), .curVal(curVal), .extLow(extLow), .curAdcShort(curAdcShort),
    .vtAdcSelTemp(vtAdcSelTemp), .gpioPinOut(gpioPinOut),
    .gpioPinOe(gpioPinOe), .intTbClk(intTbClk), .extTbClk(extTbClk),
    .curAdcData(curAdcData), .vtAdcData(vtAdcData), .gpioPinIn(gpioPinIn));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= w;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 r = regRdata;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] r);
    rd(a, r[7:0]);
    rd(a + 8'h01, r[15:8]);
  endtask
  task automatic wait_sample(output int c);
    c = 0;
    while (c < 40000 && curAdcSample !== 1'b1) begin
      @(posedge clk);
      #1 c++;
    end
    if (c == 40000) begin
      miscompares++;
      test_done();
    end
  endtask
  function automatic logic [7:0] crc8(input logic [55:0] b);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[(i / 8) * 8 + 7 - i % 8]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic t_defaults();
    rd(bgc_pkg::ADDR_MODE, d);
    `CHK(d, bgc_pkg::MODE_RESET)
    rd(bgc_pkg::ADDR_CTRL, d);
    `CHK(d[4], 1'b1)
    `CHK(d[0], 1'b0)
  endtask
  task automatic t_ram_id();
    logic [63:0] id;
    id = {8'h00, UID, PT};
    id[63:56] = crc8(id[55:0]);
    wr(8'h20, 8'hA5);
    wr(8'h3F, 8'h5A);
    wr(bgc_pkg::ADDR_ID_BASE, 8'hFF);
    wr(8'h0C, 8'h77);
    rd(8'h20, d);
    `CHK(d, 8'hA5)
    rd(8'h3F, d);
    `CHK(d, 8'h5A)
    rd(8'h0C, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 8; i++) begin
      rd(bgc_pkg::ADDR_ID_BASE + 8'(i), d);
      `CHK(d, id[i * 8 +: 8])
    end
  endtask
  task automatic t_gpio();
    wr(bgc_pkg::ADDR_MODE, 8'h18);
    #1 `CHK(curAdcShort, 1'b1)
    wr(bgc_pkg::ADDR_CTRL, 8'h00);
    #1 `CHK(gpioPinOe, 1'b1)
    wr(bgc_pkg::ADDR_CTRL, 8'h01);
    #1 `CHK(gpioPinOe, 1'b0)
    repeat (8) @(posedge clk);
    rd(bgc_pkg::ADDR_CTRL, d);
    `CHK(d[0], 1'b1)
    extLow <= 1'b1;
    repeat (8) @(posedge clk);
    rd(bgc_pkg::ADDR_CTRL, d);
    `CHK(d[0], 1'b0)
    extLow <= 1'b0;
    undervoltage <= 1'b1;
    wr(bgc_pkg::ADDR_CTRL, 8'h00);
    #1 `CHK(gpioPinOe, 1'b0)
    `CHK(gaugeActive, 1'b0)
    repeat (8) @(posedge clk);
    rd(bgc_pkg::ADDR_CTRL, d);
    `CHK(d[0], 1'b0)
    undervoltage <= 1'b0;
  endtask
  task automatic t_conv();
    curVal <= 14'h3FFD;
    wr(bgc_pkg::ADDR_MODE, 8'h14);
    wait_sample(n);
    @(posedge clk);
    #1 wait_sample(n);
    `CHK(n > 32758 && n < 32778, 1'b1)
    repeat (4) @(posedge clk);
    rd16(bgc_pkg::ADDR_CUR_LO, v);
    `CHK(v, 16'hFFFC)
    rd16(bgc_pkg::ADDR_CNT_LO, v);
    `CHK(v, 16'h0002)
    rd16(bgc_pkg::ADDR_CHG_LO, v);
    `CHK(v, 16'hFFFF)
    wr(bgc_pkg::ADDR_MODE, 8'h00);
    repeat (200) @(posedge clk);
    rd16(bgc_pkg::ADDR_CNT_LO, v);
    `CHK(v, 16'h0002)
  endtask
  task automatic t_vt();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h20, d);
    `CHK(d, 8'h00)
    rd(bgc_pkg::ADDR_CTRL, d);
    `CHK(d[4], 1'b1)
    wr(bgc_pkg::ADDR_MODE, 8'h10);
    n = 0;
    while (n < 100 && vtAdcStart !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK(n < 100, 1'b1)
    `CHK(vtAdcSelTemp, 1'b0)
    `CHK(gaugeActive, 1'b1)
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_ram_id();
    t_gpio();
    t_conv();
    t_vt();
    test_done();
  end
endmodule
